// ### logic/flash_parser_pkg.sv
package flash_parser_pkg;

    // Packet layout.
    localparam logic [7:0] CMD_WRITE_FLASH = 8'hB1;
    localparam logic [7:0] SUB_CHIP = 8'h00;
    localparam logic [7:0] SUB_PINS = 8'h01;
    localparam int IDX_CMD = 0;
    localparam int IDX_SUB = 1;
    localparam int IDX_PIN0 = 2;
    localparam int IDX_PID_LO = 8;
    localparam int IDX_PID_HI = 9;
    localparam int IDX_POWER = 10;
    localparam int IDX_CURRENT = 11;
    localparam int IDX_PASS = 12;
    localparam int PASS_BYTES = 8;
    localparam int PKT_BYTES_DOC = 64;
    localparam int PINS_DOC = 3;

    // Pin settings byte fields.
    localparam int BIT_LEVEL = 4;
    localparam int BIT_DIR = 3;
    localparam logic [2:0] FUNC_GPIO = 3'h0;
    // Highest meaningful designation code per pin; anything above is ignored.
    localparam logic [2:0] PIN_MAX_CODE [PINS_DOC] = '{3'h2, 3'h4, 3'h3};

    // Register map, byte offsets within the slave.
    localparam logic [11:0] OFF_BUF_END = 12'h040;
    localparam logic [11:0] OFF_CTRL = 12'h040;
    localparam logic [11:0] OFF_STATUS = 12'h044;
    localparam logic [11:0] OFF_CHIP = 12'h048;
    localparam logic [11:0] OFF_PASS_LO = 12'h04C;
    localparam logic [11:0] OFF_PASS_HI = 12'h050;
    localparam logic [11:0] OFF_PIN_STORED = 12'h054;
    localparam logic [11:0] OFF_PIN_APPLIED = 12'h058;
    localparam logic [11:0] OFF_ENUM = 12'h05C;

    // Control and status bits.
    localparam int CTRL_GO = 0;
    localparam int CTRL_APPLY = 1;
    localparam int STAT_DONE = 0;
    localparam int STAT_ERR = 1;
    localparam int STAT_BUSY = 2;

    // Applied pin field layout within its byte lane.
    localparam int AP_INPUT = 3;
    localparam int AP_LEVEL = 4;
    localparam int AP_GPIO = 5;

    // Reset values of the stored settings.
    localparam logic [7:0] RST_PIN = 8'h08;
    localparam logic [15:0] RST_PID = 16'h0001;
    localparam logic [7:0] RST_POWER = 8'h80;
    localparam logic [7:0] RST_CURRENT = 8'h32;

    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_PARSE
    } parse_state_t;

endpackage

// ### logic/pin_cfg_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pin_cfg_if;
    logic [7:0] setting;
    logic [2:0] code;
    logic code_ok;
    logic gpio;
    logic as_input;
    logic level;

    modport decoder (input setting, output code, output code_ok, output gpio, output as_input, output level);
    modport user (output setting, input code, input code_ok, input gpio, input as_input, input level);
endinterface
`default_nettype wire

// ### logic/pin_decode.sv
`timescale 1ns/1ns
`default_nettype none
module pin_decode
    import flash_parser_pkg::*;
#(
    parameter logic [2:0] MAX_CODE = 3'h2
) (
    // Stored settings byte in, decoded fields out.
    pin_cfg_if.decoder cfg
);

    assign cfg.code = cfg.setting[2:0];
    // Codes above the pin's highest designation are ignored.
    assign cfg.code_ok = (cfg.setting[2:0] <= MAX_CODE);
    assign cfg.gpio = (cfg.setting[2:0] == FUNC_GPIO);
    // Direction only counts in general-purpose mode.
    assign cfg.as_input = cfg.gpio & cfg.setting[BIT_DIR];
    // The reset level is driven only by a general-purpose output.
    assign cfg.level = cfg.gpio & ~cfg.setting[BIT_DIR] & cfg.setting[BIT_LEVEL];

endmodule
`default_nettype wire

// ### logic/flash_settings_write_parser.sv
`timescale 1ns/1ns
`default_nettype none
module flash_settings_write_parser
    import flash_parser_pkg::*;
#(
    parameter int PINS = 3,
    parameter int PKT_BYTES = 64
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Values reported at enumeration.
    output logic [15:0] usb_pid,
    output logic [7:0] usb_power_attr,
    output logic [8:0] usb_current_ma,
    // Stored password.
    output logic [63:0] flash_password,
    // Pin configuration in effect.
    output logic [3*PINS-1:0] pin_func,
    output logic [PINS-1:0] pin_gpio,
    output logic [PINS-1:0] pin_input,
    output logic [PINS-1:0] pin_level
);

    localparam int WORDS = PKT_BYTES / 4;

    generate
        if (PINS != PINS_DOC || PKT_BYTES != PKT_BYTES_DOC) begin : bad_cfg
            $error("flash_settings_write_parser supports only 3 pins and 64-byte packets");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave.

    logic [31:0] pkt_q [WORDS];
    logic wr_pend_q;
    logic [11:0] wr_addr_q;
    logic [31:0] rd_d;
    logic acc;
    logic go;
    logic apply_req;
    logic stat_clr_done;
    logic stat_clr_err;

    assign acc = hsel & htrans[1] & hready;

    // Writes of any size other than a whole word are dropped.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
        end else begin
            wr_pend_q <= acc & hwrite & (hsize == HSIZE_WORD);
            if (acc) begin
                wr_addr_q <= haddr[11:0];
            end
        end
    end

    // The slave never stalls and never errors, so both are held flops.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (acc && !hwrite) begin
            hrdata <= rd_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < WORDS; i++) begin
                pkt_q[i] <= 32'h0000_0000;
            end
        end else if (wr_pend_q && wr_addr_q < OFF_BUF_END) begin
            pkt_q[wr_addr_q[5:2]] <= hwdata;
        end
    end

    assign go = wr_pend_q && (wr_addr_q == OFF_CTRL) && hwdata[CTRL_GO];
    assign apply_req = wr_pend_q && (wr_addr_q == OFF_CTRL) && hwdata[CTRL_APPLY];
    assign stat_clr_done = wr_pend_q && (wr_addr_q == OFF_STATUS) && hwdata[STAT_DONE];
    assign stat_clr_err = wr_pend_q && (wr_addr_q == OFF_STATUS) && hwdata[STAT_ERR];

    function automatic logic [7:0] pkt_byte(input int idx);
        logic [31:0] w;
        w = pkt_q[idx / 4];
        return w[8 * (idx % 4) +: 8];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Parser and stored settings.

    parse_state_t st_q;
    logic done_q;
    logic err_q;
    logic [15:0] pid_q;
    logic [7:0] power_q;
    logic [7:0] current_q;
    logic [63:0] pass_q;
    logic [7:0] pin_store_q [PINS];
    logic is_flash;
    logic take_chip;
    logic take_pins;
    logic parse_bad;

    // A process rather than assigns, so that a buffer write alone re-evaluates the decode.
    always_comb begin
        is_flash = (st_q == ST_PARSE) && (pkt_byte(IDX_CMD) == CMD_WRITE_FLASH);
        take_chip = is_flash && (pkt_byte(IDX_SUB) == SUB_CHIP);
        take_pins = is_flash && (pkt_byte(IDX_SUB) == SUB_PINS);
        parse_bad = (st_q == ST_PARSE) && !take_chip && !take_pins;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= ST_IDLE;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (go) begin
                        st_q <= ST_PARSE;
                    end
                end
                ST_PARSE: begin
                    st_q <= ST_IDLE;
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Sticky flags; a new event beats a clear in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            done_q <= (take_chip || take_pins) || (done_q && !stat_clr_done);
            err_q <= parse_bad || (err_q && !stat_clr_err);
        end
    end

    // The whole group is written in the one parse cycle, so a reader never
    // sees half an update, and a rejected packet touches nothing.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pid_q <= RST_PID;
            power_q <= RST_POWER;
            current_q <= RST_CURRENT;
            pass_q <= 64'h0000_0000_0000_0000;
        end else if (take_chip) begin
            pid_q <= {pkt_byte(IDX_PID_HI), pkt_byte(IDX_PID_LO)};
            power_q <= pkt_byte(IDX_POWER);
            current_q <= pkt_byte(IDX_CURRENT);
            for (int i = 0; i < PASS_BYTES; i++) begin
                pass_q[8 * i +: 8] <= pkt_byte(IDX_PASS + i);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < PINS; i++) begin
                pin_store_q[i] <= RST_PIN;
            end
        end else if (take_pins) begin
            for (int i = 0; i < PINS; i++) begin
                pin_store_q[i] <= pkt_byte(IDX_PIN0 + i);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flash_password <= 64'h0000_0000_0000_0000;
        end else begin
            flash_password <= pass_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Applying stored settings, as the device does when it comes out of reset.

    pin_cfg_if pin_if [PINS] ();
    logic boot_q;
    logic apply;
    logic [2:0] code_w [PINS];
    logic [PINS-1:0] ok_w;
    logic [PINS-1:0] gpio_w;
    logic [PINS-1:0] input_w;
    logic [PINS-1:0] level_w;

    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : pin_dec
            assign pin_if[g].setting = pin_store_q[g];
            assign code_w[g] = pin_if[g].code;
            assign ok_w[g] = pin_if[g].code_ok;
            assign gpio_w[g] = pin_if[g].gpio;
            assign input_w[g] = pin_if[g].as_input;
            assign level_w[g] = pin_if[g].level;
            pin_decode #(
                .MAX_CODE(PIN_MAX_CODE[g])
            ) u_dec (
                .cfg(pin_if[g])
            );
        end
    endgenerate

    // Stored values reach the outputs once after reset and again on request.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_q <= 1'b1;
        end else begin
            boot_q <= 1'b0;
        end
    end

    assign apply = boot_q || apply_req;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            usb_pid <= RST_PID;
            usb_power_attr <= RST_POWER;
            usb_current_ma <= {RST_CURRENT, 1'b0};
        end else if (apply) begin
            usb_pid <= pid_q;
            usb_power_attr <= power_q;
            usb_current_ma <= {current_q, 1'b0};
        end
    end

    // An ignored designation leaves that pin as it was configured before.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_func <= '0;
            pin_gpio <= '1;
            pin_input <= '1;
            pin_level <= '0;
        end else if (apply) begin
            for (int i = 0; i < PINS; i++) begin
                if (ok_w[i]) begin
                    pin_func[3 * i +: 3] <= code_w[i];
                    pin_gpio[i] <= gpio_w[i];
                    pin_input[i] <= input_w[i];
                    pin_level[i] <= level_w[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read multiplexer.

    always_comb begin
        rd_d = 32'h0000_0000;
        if (haddr[11:0] < OFF_BUF_END) begin
            rd_d = pkt_q[haddr[5:2]];
        end else begin
            case (haddr[11:0])
                OFF_STATUS: begin
                    rd_d[STAT_DONE] = done_q;
                    rd_d[STAT_ERR] = err_q;
                    rd_d[STAT_BUSY] = (st_q == ST_PARSE);
                end
                OFF_CHIP: begin
                    rd_d = {current_q, power_q, pid_q};
                end
                OFF_PASS_LO: begin
                    rd_d = pass_q[31:0];
                end
                OFF_PASS_HI: begin
                    rd_d = pass_q[63:32];
                end
                OFF_PIN_STORED: begin
                    for (int i = 0; i < PINS; i++) begin
                        rd_d[8 * i +: 8] = pin_store_q[i];
                    end
                end
                OFF_PIN_APPLIED: begin
                    for (int i = 0; i < PINS; i++) begin
                        rd_d[8 * i +: 3] = pin_func[3 * i +: 3];
                        rd_d[8 * i + AP_INPUT] = pin_input[i];
                        rd_d[8 * i + AP_LEVEL] = pin_level[i];
                        rd_d[8 * i + AP_GPIO] = pin_gpio[i];
                    end
                end
                OFF_ENUM: begin
                    rd_d = {7'h00, usb_current_ma, usb_power_attr, 8'h00};
                end
                default: begin
                    rd_d = 32'h0000_0000;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ### dv/parser_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module parser_asserts
    import flash_parser_pkg::*;
#(
    parameter int PINS = 3
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Bus.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Applied settings.
    input wire logic [15:0] usb_pid,
    input wire logic [7:0] usb_power_attr,
    input wire logic [8:0] usb_current_ma,
    input wire logic [63:0] flash_password,
    input wire logic [3*PINS-1:0] pin_func,
    input wire logic [PINS-1:0] pin_gpio,
    input wire logic [PINS-1:0] pin_input,
    input wire logic [PINS-1:0] pin_level
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic ctrl_wr_q;
    logic apply_q;
    logic go_q;
    ////////////////////////////////////////
    // Tracks control writes so output changes can be tied to their cause.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_wr_q <= 1'b0;
            apply_q <= 1'b0;
            go_q <= 1'b0;
        end else begin
            ctrl_wr_q <= hsel && htrans[1] && hready && hwrite && hsize == HSIZE_WORD && haddr[11:0] == OFF_CTRL;
            apply_q <= ctrl_wr_q && hwdata[CTRL_APPLY];
            go_q <= ctrl_wr_q && hwdata[CTRL_GO];
        end
    end
    ////////////////////////////////////////
    apply_only_a: assert property ($changed({usb_pid, usb_power_attr, usb_current_ma, pin_func, pin_gpio,
        pin_input, pin_level}) |-> apply_q) else $error("outputs changed without apply");
    pass_store_a: assert property ($changed(flash_password) |->
        $past(go_q) || $past(go_q, 2) || $past(go_q, 3)) else $error("password changed without parse");
    reset_vals_a: assert property ($rose(hresetn) |-> usb_pid == RST_PID && usb_power_attr == RST_POWER
        && usb_current_ma == {RST_CURRENT, 1'b0}) else $error("wrong values after reset");
    current_even_a: assert property (!usb_current_ma[0]) else $error("current not twice a byte");
    input_gpio_a: assert property ((pin_input & ~pin_gpio) == '0) else $error("input set off gpio");
    level_out_a: assert property ((pin_level & (pin_input | ~pin_gpio)) == '0) else $error("level not output");
    gpio_code_a: assert property (pin_gpio == {pin_func[8:6] == FUNC_GPIO, pin_func[5:3] == FUNC_GPIO,
        pin_func[2:0] == FUNC_GPIO}) else $error("gpio flag disagrees with code");
    code_range_a: assert property (pin_func[2:0] <= PIN_MAX_CODE[0] && pin_func[5:3] <= PIN_MAX_CODE[1]
        && pin_func[8:6] <= PIN_MAX_CODE[2]) else $error("ignored code applied");
    apply_cov: cover property (apply_q);
    go_cov: cover property (go_q);
    level_cov: cover property (pin_level != '0);
endmodule
bind flash_settings_write_parser parser_asserts #(.PINS(PINS)) chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .usb_pid, .usb_power_attr, .usb_current_ma,
    .flash_password, .pin_func, .pin_gpio, .pin_input, .pin_level);
`default_nettype wire

// ### dv/usb_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module usb_host_model
    import flash_parser_pkg::*;
(
    // Report content.
    input wire logic [7:0] sub,
    input wire logic [23:0] pins,
    input wire logic [95:0] chip,
    // Word of the report.
    input wire logic [3:0] idx,
    output logic [31:0] word
);
    logic [7:0] pkt [64];
    always_comb begin
        pkt = '{default: 8'h00};
        pkt[IDX_CMD] = CMD_WRITE_FLASH;
        pkt[IDX_SUB] = sub;
        for (int i = 0; i < 3; i++) begin
            pkt[IDX_PIN0 + i] = pins[8*i+:8];
        end
        for (int i = 0; i < 12; i++) begin
            pkt[IDX_PID_LO + i] = chip[8*i+:8];
        end
        word = {pkt[4*idx+3], pkt[4*idx+2], pkt[4*idx+1], pkt[4*idx]};
    end
endmodule
`default_nettype wire

// ### dv/flash_settings_write_parser_test.sv
`timescale 1ns/1ns
`default_nettype none
module flash_settings_write_parser_test
    import flash_parser_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [15:0] usb_pid;
    logic [7:0] usb_power_attr;
    logic [8:0] usb_current_ma;
    logic [63:0] flash_password;
    logic [8:0] pin_func;
    logic [2:0] pin_gpio;
    logic [2:0] pin_input;
    logic [2:0] pin_level;
    logic [7:0] sub = 8'h00;
    logic [23:0] pins = 24'h0;
    logic [95:0] chip = 96'h0;
    logic [3:0] idx = 4'h0;
    logic [31:0] word;
    logic [31:0] rd;
    logic [7:0] e;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;
    // Each row: stored bytes {pin2, pin1, pin0}, then applied bytes in the same order.
    logic [47:0] rows [9] = '{48'hF01810_302830, 48'h190901_010101, 48'h020202_020202, 48'h030303_030302,
        48'h040404_030402, 48'h05050D_030402, 48'h060606_030402, 48'h07071F_030402, 48'h100018_302028};
    assign hready = hreadyout;
    flash_settings_write_parser dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .usb_pid, .usb_power_attr, .usb_current_ma, .flash_password, .pin_func,
        .pin_gpio, .pin_input, .pin_level);
    usb_host_model host_u (.sub, .pins, .chip, .idx, .word);
    initial begin
        forever #20 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            close_out();
        end
    end
    ////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // The buffer is only rewritten once busy has dropped, though a write during parse lands after the parse has read the buffer.
    task automatic send(input logic [7:0] s, input logic [23:0] p, input logic [95:0] c, input logic [1:0] st);
        sub = s;
        pins = p;
        chip = c;
        for (int i = 0; i < 5; i++) begin
            idx = 4'(i);
            #1;
            xfer(12'(4 * i), 1'b1, word);
        end
        xfer(OFF_CTRL, 1'b1, 32'h1);
        rd = 32'h4;
        for (int n = 0; n < 20 && rd[STAT_BUSY]; n++) xfer(OFF_STATUS, 1'b0, 32'h0);
        chk(rd[2:0], {1'b0, st});
        xfer(OFF_STATUS, 1'b1, 32'h3);
        xfer(OFF_CTRL, 1'b1, 32'h2);
        repeat (2) @(posedge hclk);
    endtask
    task automatic reset_check();
        for (int k = 0; k < 2; k++) begin
            repeat (3) @(posedge hclk);
            chk({usb_pid, usb_power_attr, usb_current_ma, pin_func, pin_gpio, pin_input, pin_level,
                hreadyout, hresp}, {RST_PID, RST_POWER, RST_CURRENT, 1'b0, 9'h0, 3'h7, 3'h7, 3'h0, 1'b1, 1'b0});
            hresetn <= 1'b1;
        end
    endtask
    ////////////////////////////////////////
    initial begin
        reset_check();
        for (int r = 0; r < 9; r++) begin
            send(SUB_PINS, rows[r][47:24], 96'h0, 2'b01);
            xfer(OFF_PIN_STORED, 1'b0, 32'h0);
            chk(rd, rows[r][47:24]);
            xfer(OFF_PIN_APPLIED, 1'b0, 32'h0);
            chk(rd, rows[r][23:0]);
            for (int i = 0; i < 3; i++) begin
                e = rows[r][8*i+:8];
                chk({pin_func[3*i+:3], pin_input[i], pin_level[i], pin_gpio[i]}, {e[2:0], e[3], e[4], e[5]});
            end
        end
        send(SUB_CHIP, 24'h0, {64'h0807060504030201, 8'hFA, 8'hC0, 16'h1234}, 2'b01);
        chk(usb_pid, 16'h1234);
        chk(usb_power_attr, 8'hC0);
        chk(usb_current_ma, 9'h1F4);
        chk(flash_password, 64'h0807060504030201);
        xfer(OFF_CHIP, 1'b0, 32'h0);
        chk(rd, 32'hFAC01234);
        send(8'h05, 24'h0, {64'h0, 8'h10, 8'h20, 16'h5555}, 2'b10);
        chk({usb_pid, usb_current_ma}, {16'h1234, 9'h1F4});
        xfer(OFF_PIN_STORED, 1'b0, 32'h0);
        chk(rd, 32'h100018);
        xfer(12'h060, 1'b1, 32'hFFFFFFFF);
        xfer(12'h060, 1'b0, 32'h0);
        chk(rd, 32'h0);
        // A write narrower than a word must leave the packet buffer alone.
        @(posedge hclk);
        hsize <= 3'h0;
        xfer(12'h000, 1'b1, 32'hFFFFFFFF);
        hsize <= HSIZE_WORD;
        xfer(12'h000, 1'b0, 32'h0);
        chk(rd, 32'h000005B1);
        @(posedge hclk);
        hresetn <= 1'b0;
        reset_check();
        close_out();
    end
endmodule
`default_nettype wire
